/* src/hfe_pkg.sv */
// Package: register map, field positions and timing constants of the frame enhancement block
package hfe_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_TX_ENH = 8'h00; // tx_enhancement_config
  localparam logic [7:0] ADDR_LINE_FMT = 8'h04; // line_format_config
  localparam logic [7:0] ADDR_EXT_INT = 8'h08; // ext_status_int_config
  localparam logic [7:0] ADDR_RX_MODE = 8'h0C; // receive interrupt mode
  localparam logic [7:0] ADDR_CMD = 8'h10; // command strobes
  localparam logic [7:0] ADDR_SRX_STAT = 8'h14; // special_rx_status
  localparam logic [7:0] ADDR_CNT_LO = 8'h18; // frame_byte_count_low
  localparam logic [7:0] ADDR_CNT_HI = 8'h1C; // frame_byte_count_high
  localparam logic [7:0] ADDR_TX_DATA = 8'h20; // transmit data
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADDR_STATE = 8'h2C; // block state readback
  // Field positions
  localparam int TXE_AUTO_FLAG = 0;
  localparam int TXE_AUTO_EOM = 1;
  localparam int LF_MARK_IDLE = 3;
  localparam int LF_NRZ_SEL = 5;
  localparam int LF_NRZ_SEL2 = 6;
  localparam int EI_STAT_FIFO = 2;
  localparam int CMD_ERR_RESET = 0;
  localparam int CMD_RESET_IUS = 1;
  localparam int CMD_RESET_EOM = 2;
  localparam int IRQ_SPECIAL = 0;
  localparam int IRQ_RX_AVAIL = 1;
  localparam int IRQ_TX_EOM = 2;
  localparam int IRQ_BITS = 3;
  // Receive interrupt modes
  localparam logic [1:0] RXM_OFF = 2'h0;
  localparam logic [1:0] RXM_FIRST = 2'h1;
  localparam logic [1:0] RXM_ALL = 2'h2;
  localparam logic [1:0] RXM_SPECIAL = 2'h3;
  // Reset values
  localparam logic [7:0] TX_ENH_RST = 8'h00;
  localparam logic [7:0] LINE_FMT_RST = 8'h00;
  localparam logic [7:0] EXT_INT_RST = 8'h00;
  // Timing: write data captured this long after the strobe
  localparam int WR_LATCH_NS = 20;
  localparam int CLK_NS = 10;
  localparam int WR_LATCH_CYC = (WR_LATCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_CYC = 8; // bit-time enable divider
  // Serial flag pattern
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
endpackage

/* src/hfe_top.sv */
// Frame enhancement logic of one channel: transmit framing, status FIFO handling, bus slave
`timescale 1ns/1ps

// Operation
// - Auto flag: opening flag sent before data
// - NRZI mark idle forces line high
// - Status FIFO enhancement only when enabled
// - End of frame loads counts and status only with the status FIFO enabled
// - Any of three modes raises special interrupt
// - Reading status locks data FIFO otherwise, in first-character and special-only modes
// - Overrun always special and locks FIFO
// - Enhanced end of frame: data-available, no lock
// - That interrupt needs no receive enable
// - Auto end-of-message: accept next frame data early
// - Shared flag needs both auto features
// - Write data captured shortly after strobe
module hfe_top #(
  parameter int CNT_W = 16
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic rx_eof_i,
  input wire logic [CNT_W-1:0] rx_count_i,
  input wire logic [7:0] rx_status_i,
  input wire logic rx_overrun_i,
  input wire logic rx_char_i,
  output logic rx_fifo_locked_o,
  output logic txd_o,
  output logic irq_o
);
  // Elaboration check: the count readback holds two bytes at most
  if (CNT_W < 9 || CNT_W > 16)
  begin : g_bad_cnt_w
    $error("CNT_W must be 9..16");
  end

  // ****************************************
  // Bus slave
  // ****************************************
  typedef enum logic [2:0] {
    HFE_BUS_IDLE = 3'b001,
    HFE_BUS_WAIT = 3'b010,
    HFE_BUS_ACK = 3'b100
  } hfe_bus_t;
  hfe_bus_t bus_reg;
  hfe_bus_t bus_next;
  logic [1:0] wait_reg;
  logic [31:0] wdat_reg;
  logic [7:0] tx_enh_reg;
  logic [7:0] line_fmt_reg;
  logic [7:0] ext_int_reg;
  logic [1:0] rx_mode_reg;
  logic [7:0] srx_stat_reg;
  logic [15:0] cnt_reg;
  logic [hfe_pkg::IRQ_BITS-1:0] irq_stat_reg;
  logic [hfe_pkg::IRQ_BITS-1:0] irq_mask_reg;
  logic locked_reg;
  logic eom_reg;
  logic ius_reg;
  logic [31:0] rdata_reg;
  wire req = wb_cyc_i & wb_stb_i;
  wire lane0 = wb_sel_i[0];
  // Data latched after the strobe settles, not on its first edge
  wire wr_fire = (bus_reg == HFE_BUS_WAIT) && (wait_reg == 2'(hfe_pkg::WR_LATCH_CYC)) && wb_we_i && lane0;
  wire rd_fire = (bus_reg == HFE_BUS_WAIT) && (wait_reg == 2'(hfe_pkg::WR_LATCH_CYC)) && !wb_we_i;
  wire [7:0] wd = wdat_reg[7:0];
  wire wr_txe = wr_fire && wb_adr_i == hfe_pkg::ADDR_TX_ENH;
  wire wr_lf = wr_fire && wb_adr_i == hfe_pkg::ADDR_LINE_FMT;
  wire wr_ei = wr_fire && wb_adr_i == hfe_pkg::ADDR_EXT_INT;
  wire wr_rxm = wr_fire && wb_adr_i == hfe_pkg::ADDR_RX_MODE;
  wire wr_cmd = wr_fire && wb_adr_i == hfe_pkg::ADDR_CMD;
  wire wr_txd = wr_fire && wb_adr_i == hfe_pkg::ADDR_TX_DATA;
  wire wr_ist = wr_fire && wb_adr_i == hfe_pkg::ADDR_IRQ_STAT;
  wire wr_imk = wr_fire && wb_adr_i == hfe_pkg::ADDR_IRQ_MASK;
  wire rd_srx = rd_fire && wb_adr_i == hfe_pkg::ADDR_SRX_STAT;
  wire cmd_err_rst = wr_cmd && wd[hfe_pkg::CMD_ERR_RESET];
  wire cmd_ius_rst = wr_cmd && wd[hfe_pkg::CMD_RESET_IUS];
  wire cmd_eom_rst = wr_cmd && wd[hfe_pkg::CMD_RESET_EOM];

  // Bus sequencing: latch, wait for settle, ack one cycle
  always_comb
  begin
    bus_next = bus_reg;
    unique case (bus_reg)
      HFE_BUS_IDLE: if (req) bus_next = HFE_BUS_WAIT;
      HFE_BUS_WAIT: if (wait_reg == 2'(hfe_pkg::WR_LATCH_CYC)) bus_next = HFE_BUS_ACK;
      HFE_BUS_ACK: bus_next = HFE_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_reg <= HFE_BUS_IDLE;
      wait_reg <= 2'h0;
      wdat_reg <= 32'h0000_0000;
    end
    else
    begin
      bus_reg <= bus_next;
      wait_reg <= (bus_reg == HFE_BUS_WAIT) ? wait_reg + 2'h1 : 2'h0;
      if (bus_reg == HFE_BUS_WAIT) wdat_reg <= wb_dat_i; // Sampled late, after strobe
    end
  end
  assign wb_ack_o = (bus_reg == HFE_BUS_ACK);

  // Read mux; unmapped reads return zero
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0000_0000;
    case (wb_adr_i)
      hfe_pkg::ADDR_TX_ENH: rmux = {24'h0, tx_enh_reg};
      hfe_pkg::ADDR_LINE_FMT: rmux = {24'h0, line_fmt_reg};
      hfe_pkg::ADDR_EXT_INT: rmux = {24'h0, ext_int_reg};
      hfe_pkg::ADDR_RX_MODE: rmux = {30'h0, rx_mode_reg};
      hfe_pkg::ADDR_SRX_STAT: rmux = {24'h0, srx_stat_reg};
      hfe_pkg::ADDR_CNT_LO: rmux = {24'h0, cnt_reg[7:0]};
      hfe_pkg::ADDR_CNT_HI: rmux = {24'h0, cnt_reg[15:8]};
      hfe_pkg::ADDR_IRQ_STAT: rmux = {29'h0, irq_stat_reg};
      hfe_pkg::ADDR_IRQ_MASK: rmux = {29'h0, irq_mask_reg};
      hfe_pkg::ADDR_STATE: rmux = {28'h0, ius_reg, eom_reg, locked_reg, txd_o};
      default: rmux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i) rdata_reg <= 32'h0000_0000;
    else if (rd_fire) rdata_reg <= rmux;
  end
  assign wb_dat_o = rdata_reg;

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_enh_reg <= hfe_pkg::TX_ENH_RST;
      line_fmt_reg <= hfe_pkg::LINE_FMT_RST;
      ext_int_reg <= hfe_pkg::EXT_INT_RST;
      rx_mode_reg <= hfe_pkg::RXM_OFF;
      irq_mask_reg <= '0;
    end
    else
    begin
      if (wr_txe) tx_enh_reg <= wd;
      if (wr_lf) line_fmt_reg <= wd;
      if (wr_ei) ext_int_reg <= wd;
      if (wr_rxm) rx_mode_reg <= wd[1:0];
      if (wr_imk) irq_mask_reg <= wd[hfe_pkg::IRQ_BITS-1:0];
    end
  end
  wire auto_flag = tx_enh_reg[hfe_pkg::TXE_AUTO_FLAG];
  wire auto_eom = tx_enh_reg[hfe_pkg::TXE_AUTO_EOM];
  wire mark_idle = line_fmt_reg[hfe_pkg::LF_MARK_IDLE];
  wire nrzi = line_fmt_reg[hfe_pkg::LF_NRZ_SEL] & ~line_fmt_reg[hfe_pkg::LF_NRZ_SEL2];
  wire stat_fifo_en = ext_int_reg[hfe_pkg::EI_STAT_FIFO];

  // ****************************************
  // Receive end-of-frame handling
  // ****************************************
  wire rx_int_any = rx_mode_reg != hfe_pkg::RXM_OFF;
  wire lock_mode = rx_mode_reg == hfe_pkg::RXM_FIRST || rx_mode_reg == hfe_pkg::RXM_SPECIAL;
  wire enh_eof = stat_fifo_en && rx_mode_reg == hfe_pkg::RXM_SPECIAL;
  wire eof_special = rx_eof_i && rx_int_any && !enh_eof;
  wire ovr_special = rx_overrun_i; // Always special
  wire eof_avail = rx_eof_i && enh_eof; // Regardless of receive-char enable
  // Plain character available only where software asked for every character
  wire char_avail = rx_char_i && rx_mode_reg == hfe_pkg::RXM_ALL;
  logic eof_pend_reg;
  logic lock_arm_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      srx_stat_reg <= 8'h00;
      cnt_reg <= 16'h0000;
      eof_pend_reg <= 1'b0;
      lock_arm_reg <= 1'b0;
      locked_reg <= 1'b0;
      ius_reg <= 1'b0;
    end
    else
    begin
      if (rx_eof_i && stat_fifo_en)
      begin
        cnt_reg <= 16'(rx_count_i);
        srx_stat_reg <= rx_status_i;
      end
      // Lock arms on a special condition that may lock
      if (ovr_special || (eof_special && lock_mode)) lock_arm_reg <= 1'b1;
      else if (rd_srx) lock_arm_reg <= 1'b0;
      // Lock when serviced; the set wins over the error reset
      if (rd_srx && lock_arm_reg) locked_reg <= 1'b1;
      else if (cmd_err_rst) locked_reg <= 1'b0;
      if (eof_avail) ius_reg <= 1'b1;
      else if (cmd_ius_rst) ius_reg <= 1'b0;
      eof_pend_reg <= eof_avail;
    end
  end
  assign rx_fifo_locked_o = locked_reg;

  // ****************************************
  // Transmit framing
  // ****************************************
  typedef enum logic [3:0] {
    HFE_TX_IDLE = 4'b0001,
    HFE_TX_FLAG = 4'b0010,
    HFE_TX_DATA = 4'b0100,
    HFE_TX_CLOSE = 4'b1000
  } hfe_tx_t;
  hfe_tx_t tx_reg;
  hfe_tx_t tx_next;
  logic [2:0] bitdiv_reg;
  logic [2:0] bitcnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic line_reg;
  wire bit_en = bitdiv_reg == 3'(hfe_pkg::BIT_CYC - 1);
  wire byte_end = bit_en && bitcnt_reg == 3'h7;
  wire tx_eom_ev = byte_end && tx_reg == HFE_TX_DATA && !hold_full_reg;
  // Early acceptance only with auto end-of-message
  wire accept = !hold_full_reg && (tx_reg != HFE_TX_CLOSE || auto_eom);
  // Shared flag: closing flag doubles as opening flag
  wire shared = auto_eom && auto_flag && hold_full_reg;

  // Transmit state progression
  always_comb
  begin
    tx_next = tx_reg;
    unique case (tx_reg)
      HFE_TX_IDLE: if (hold_full_reg && (auto_flag || !mark_idle)) tx_next = HFE_TX_FLAG;
      HFE_TX_FLAG: if (byte_end) tx_next = HFE_TX_DATA;
      HFE_TX_DATA: if (tx_eom_ev) tx_next = HFE_TX_CLOSE;
      HFE_TX_CLOSE: if (byte_end) tx_next = shared ? HFE_TX_DATA : HFE_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_reg <= HFE_TX_IDLE;
      bitdiv_reg <= 3'h0;
      bitcnt_reg <= 3'h0;
      shift_reg <= 8'hFF;
      hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      eom_reg <= 1'b0;
    end
    else
    begin
      tx_reg <= tx_next;
      bitdiv_reg <= bit_en ? 3'h0 : bitdiv_reg + 3'h1;
      if (tx_reg == HFE_TX_IDLE) bitcnt_reg <= 3'h0;
      else if (bit_en) bitcnt_reg <= bitcnt_reg + 3'h1;
      if (tx_reg == HFE_TX_IDLE && tx_next == HFE_TX_FLAG) shift_reg <= hfe_pkg::FLAG_BYTE;
      else if (byte_end && tx_next == HFE_TX_DATA)
        shift_reg <= hold_reg;
      else if (byte_end && tx_next == HFE_TX_CLOSE)
        shift_reg <= hfe_pkg::FLAG_BYTE;
      else if (bit_en)
        shift_reg <= {1'b1, shift_reg[7:1]};
      // Hold register fills on data write, drains at byte boundary
      if (wr_txd && accept)
      begin
        hold_reg <= wd;
        hold_full_reg <= 1'b1;
      end
      else if (byte_end && tx_next == HFE_TX_DATA)
        hold_full_reg <= 1'b0;
      // End-of-message latch: set wins; auto clear on data write
      if (tx_eom_ev) eom_reg <= 1'b1;
      else if ((wr_txd && auto_eom) || cmd_eom_rst) eom_reg <= 1'b0;
    end
  end

  // Line level: NRZI mark idle forces high while the transmitter is idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i) line_reg <= 1'b1;
    else if (tx_reg == HFE_TX_IDLE && nrzi && mark_idle) line_reg <= 1'b1;
    else if (bit_en && tx_reg != HFE_TX_IDLE && !shift_reg[0]) line_reg <= nrzi ? ~line_reg : 1'b0;
    else if (bit_en && !nrzi) line_reg <= shift_reg[0] | (tx_reg == HFE_TX_IDLE);
  end
  assign txd_o = line_reg;

  // ****************************************
  // Interrupts
  // ****************************************
  logic [hfe_pkg::IRQ_BITS-1:0] ev;
  assign ev = {tx_eom_ev, eof_pend_reg | char_avail, eof_special | ovr_special};
  always_ff @(posedge clk_i)
  begin
    if (rst_i) irq_stat_reg <= '0;
    else irq_stat_reg <= ev | (irq_stat_reg & ~(wr_ist ? wd[hfe_pkg::IRQ_BITS-1:0] : '0));
  end
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // Checks
  // ****************************************
  chk_shared_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_reg == HFE_TX_CLOSE && tx_next == HFE_TX_DATA) |-> (auto_eom && auto_flag))
    else $error("shared flag without both auto features");
  chk_idle_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_reg == HFE_TX_IDLE && nrzi && mark_idle) |=> txd_o)
    else $error("line not high at mark idle");
  chk_overrun_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (lock_arm_reg && rd_srx) |=> locked_reg)
    else $error("overrun did not lock");
  chk_enh_nolock: assert property (@(posedge clk_i) disable iff (rst_i)
    (eof_avail && !lock_arm_reg && !rx_overrun_i) |=> !lock_arm_reg)
    else $error("enhanced eof armed lock");
  chk_eof_avail: assert property (@(posedge clk_i) disable iff (rst_i)
    eof_avail |-> ##2 irq_stat_reg[hfe_pkg::IRQ_RX_AVAIL])
    else $error("no data-available on eof");
  chk_eof_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_eof_i && stat_fifo_en) |=> srx_stat_reg == $past(rx_status_i))
    else $error("status not loaded");
  chk_err_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_err_rst && !(rd_srx && lock_arm_reg)) |=> !locked_reg)
    else $error("error reset did not unlock");
  chk_wr_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_reg == HFE_BUS_IDLE && req) |=> !wr_fire)
    else $error("write taken at strobe");
  chk_eom_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_txd && auto_eom && !tx_eom_ev) |=> !eom_reg)
    else $error("eom latch not auto-cleared");
  chk_flag_first: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_reg == HFE_TX_IDLE && tx_next == HFE_TX_FLAG) |=> shift_reg == hfe_pkg::FLAG_BYTE)
    else $error("opening flag not loaded");
endmodule

/* testbench/hfe_station.sv */
// Far-side station model: drives the receive events that the line side reports
`timescale 1ns/1ps
// ****
// Station model
// ****
module hfe_station (
  input wire logic clk_i,
  output logic rx_eof_o,
  output logic [15:0] rx_count_o,
  output logic [7:0] rx_status_o,
  output logic rx_overrun_o,
  output logic rx_char_o
);
  // Idle levels at time zero
  initial
  begin
    rx_eof_o = 1'b0;
    rx_count_o = 16'h0000;
    rx_status_o = 8'h00;
    rx_overrun_o = 1'b0;
    rx_char_o = 1'b0;
  end
  // One character, then end of frame; count and status are only valid with the pulse
  task send_eof(input logic [15:0] cnt, input logic [7:0] st);
    @(posedge clk_i);
    rx_char_o <= 1'b1;
    @(posedge clk_i);
    rx_char_o <= 1'b0;
    rx_eof_o <= 1'b1;
    rx_count_o <= cnt;
    rx_status_o <= st;
    @(posedge clk_i);
    rx_eof_o <= 1'b0;
    rx_count_o <= ~cnt; // Stale value inverted so a late capture shows
    rx_status_o <= ~st;
  endtask
  // One-cycle overrun pulse
  task send_overrun;
    @(posedge clk_i);
    rx_overrun_o <= 1'b1;
    @(posedge clk_i);
    rx_overrun_o <= 1'b0;
  endtask
endmodule

/* testbench/hdlc_frame_enhancements_bench.sv */
// Self-checking bench of the frame enhancement block
`timescale 1ns/1ps
module hdlc_frame_enhancements_bench;
  // ****
  // Signals
  // ****
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_r;
  logic [31:0] rd;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic ack, eof, ovr, chr, locked, txd, irq;
  logic [15:0] cnt;
  logic [7:0] st;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Design and station
  hfe_top #(.CNT_W(16)) i_hfe_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(dat_r), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .rx_eof_i(eof), .rx_count_i(cnt), .rx_status_i(st), .rx_overrun_i(ovr), .rx_char_i(chr),
    .rx_fifo_locked_o(locked), .txd_o(txd), .irq_o(irq));
  hfe_station i_hfe_station (.clk_i(clk_i), .rx_eof_o(eof), .rx_count_o(cnt), .rx_status_o(st),
    .rx_overrun_o(ovr), .rx_char_o(chr));
  // Clock and hang guard; the whole run needs well under the ceiling
  initial
    forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  // ****
  // Shared tasks
  // ****
  task print_verdict;
    $display("Tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task check_bit(input logic got, input logic exp, input string msg);
    check_word({31'h0, got}, {31'h0, exp}, msg);
  endtask
  // Classic cycle; ack seen at an edge ends it, then two idle cycles let outputs settle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    check_bit(ack, 1'b1, "ack");
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
    check_word(rd, exp, msg);
  endtask
  task wait_sig(input logic use_irq, input logic lvl, input int bound);
    int n;
    n = 0;
    while ((use_irq ? irq : txd) !== lvl && n < bound)
    begin
      @(posedge clk_i);
      n++;
    end
    check_bit(use_irq ? irq : txd, lvl, "wait");
  endtask
  task hold_txd(input int ncyc);
    logic ok;
    ok = 1'b1;
    repeat (ncyc)
    begin
      @(posedge clk_i);
      if (txd !== 1'b1)
        ok = 1'b0;
    end
    check_bit(ok, 1'b1, "txd idle");
  endtask
  // ****
  // Scenarios
  // ****
  // Reset values, unmapped read, write without byte lane 0
  task t_reset;
    check_bit(txd, 1'b1, "txd rst");
    check_bit(irq, 1'b0, "irq rst");
    rdc(hfe_pkg::ADDR_TX_ENH, {24'h0, hfe_pkg::TX_ENH_RST}, "txe rst");
    rdc(hfe_pkg::ADDR_LINE_FMT, {24'h0, hfe_pkg::LINE_FMT_RST}, "lf rst");
    rdc(hfe_pkg::ADDR_EXT_INT, {24'h0, hfe_pkg::EXT_INT_RST}, "ei rst");
    rdc(8'h3C, 32'h0000_0000, "unmapped");
    wb(1'b1, hfe_pkg::ADDR_TX_ENH, 32'h0000_0003, 4'hE);
    rdc(hfe_pkg::ADDR_TX_ENH, 32'h0000_0000, "sel0 write");
    wr(hfe_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
  endtask
  // Every receive mode without the status FIFO: special interrupt and lock
  task t_modes;
    for (int m = 0; m < 4; m++)
    begin
      wr(hfe_pkg::ADDR_RX_MODE, 32'(m));
      i_hfe_station.send_eof(16'h0100, 8'h80);
      wb(1'b0, hfe_pkg::ADDR_IRQ_STAT, 32'h0000_0000, 4'hF);
      check_bit(rd[hfe_pkg::IRQ_SPECIAL], m != 0, "special");
      check_bit(rd[hfe_pkg::IRQ_RX_AVAIL], m == 2, "char avail");
      wb(1'b0, hfe_pkg::ADDR_SRX_STAT, 32'h0000_0000, 4'hF);
      check_bit(locked, m == 1 || m == 3, "lock");
      wr(hfe_pkg::ADDR_CMD, 32'h0000_0003);
      check_bit(locked, 1'b0, "unlock");
      wr(hfe_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
    end
  endtask
  // Status FIFO on, special-only mode: counts, status, data-available, no lock
  task t_enhanced;
    wr(hfe_pkg::ADDR_EXT_INT, 32'h0000_0004);
    wr(hfe_pkg::ADDR_RX_MODE, {30'h0, hfe_pkg::RXM_SPECIAL});
    i_hfe_station.send_eof(16'h1234, 8'hA5);
    rdc(hfe_pkg::ADDR_IRQ_STAT, 32'h0000_0002, "eof avail");
    check_bit(irq, 1'b1, "irq eof");
    rdc(hfe_pkg::ADDR_CNT_LO, 32'h0000_0034, "cnt lo");
    rdc(hfe_pkg::ADDR_CNT_HI, 32'h0000_0012, "cnt hi");
    rdc(hfe_pkg::ADDR_SRX_STAT, 32'h0000_00A5, "status");
    check_bit(locked, 1'b0, "no lock");
    wr(hfe_pkg::ADDR_CMD, 32'h0000_0002);
    wr(hfe_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
    check_bit(irq, 1'b0, "irq clr");
  endtask
  // Overrun under the enhancement still locks; mask gates the output
  task t_overrun;
    wr(hfe_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    i_hfe_station.send_overrun();
    rdc(hfe_pkg::ADDR_IRQ_STAT, 32'h0000_0001, "ovr stat");
    check_bit(irq, 1'b0, "masked");
    wr(hfe_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    check_bit(irq, 1'b1, "unmasked");
    wb(1'b0, hfe_pkg::ADDR_SRX_STAT, 32'h0000_0000, 4'hF);
    check_bit(locked, 1'b1, "ovr lock");
    wr(hfe_pkg::ADDR_CMD, 32'h0000_0001);
    check_bit(locked, 1'b0, "ovr unlock");
    wr(hfe_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    check_bit(irq, 1'b0, "w1c");
    wr(hfe_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
  endtask
  // No auto flag and mark idle set: nothing leaves until mark idle is cleared
  task t_tx_hold;
    wr(hfe_pkg::ADDR_LINE_FMT, 32'h0000_0008);
    wr(hfe_pkg::ADDR_TX_DATA, 32'h0000_0055);
    hold_txd(100);
    wr(hfe_pkg::ADDR_LINE_FMT, 32'h0000_0000);
    wait_sig(1'b0, 1'b0, 200);
  endtask
  // NRZI mark idle with both auto features: flag, early next frame, line high after
  task t_tx_auto;
    wr(hfe_pkg::ADDR_LINE_FMT, 32'h0000_0028);
    rdc(hfe_pkg::ADDR_LINE_FMT, 32'h0000_0028, "lf rb");
    repeat (800) @(posedge clk_i);
    wb(1'b0, hfe_pkg::ADDR_STATE, 32'h0000_0000, 4'hF);
    check_bit(rd[2], 1'b1, "eom set");
    wr(hfe_pkg::ADDR_CMD, 32'h0000_0004);
    wb(1'b0, hfe_pkg::ADDR_STATE, 32'h0000_0000, 4'hF);
    check_bit(rd[2], 1'b0, "eom cmd");
    wr(hfe_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
    hold_txd(16);
    wr(hfe_pkg::ADDR_TX_ENH, 32'h0000_0003);
    wr(hfe_pkg::ADDR_TX_DATA, 32'h0000_0055);
    wait_sig(1'b0, 1'b0, 200);
    wait_sig(1'b1, 1'b1, 2000);
    wr(hfe_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
    wr(hfe_pkg::ADDR_TX_DATA, 32'h0000_00AA);
    wb(1'b0, hfe_pkg::ADDR_STATE, 32'h0000_0000, 4'hF);
    check_bit(rd[2], 1'b0, "eom clr");
    wait_sig(1'b1, 1'b1, 2000);
    wr(hfe_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
    repeat (600) @(posedge clk_i);
    hold_txd(64);
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_modes();
    t_enhanced();
    t_overrun();
    t_tx_hold();
    t_tx_auto();
    print_verdict();
  end
endmodule
